// >>> hw/dic_top.sv
module dic_top #(
   parameter int N_IN = 8,
   parameter logic [31:0] CNT_MASK = 32'hFFFFFFFF,
   parameter int MS_CYCLES = dic_pkg::MS_CYCLES
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic [N_IN-1:0] field_in,
   input wire logic [11:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic [N_IN-1:0] din_status,
   output logic [N_IN-1:0] line_invalid_flag,
   output logic [N_IN-1:0] osc_event
);
   localparam int DIVW = $clog2(MS_CYCLES + 1);
   localparam logic [DIVW-1:0] DIV_LAST = DIVW'(MS_CYCLES - 1);
   localparam logic [9:0] WIN_LAST = 10'(dic_pkg::WIN_MS - 1);
   localparam logic [9:0] REF_LAST = 10'(dic_pkg::REFRESH_MS - 1);

   // millisecond time base
   logic [DIVW-1:0] div_r;
   logic tick_r;
   logic [31:0] now_ms_r;
   logic [9:0] win_r;
   logic [9:0] ref_r;
   wire div_wrap = (div_r == DIV_LAST);
   wire win_end = tick_r && (win_r == WIN_LAST);
   wire ref_end = tick_r && (ref_r == REF_LAST);

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         div_r <= '0;
         tick_r <= 1'b0;
      end else begin
         div_r <= div_wrap ? '0 : div_r + DIVW'(1);
         tick_r <= div_wrap;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         now_ms_r <= '0;
         win_r <= '0;
         ref_r <= '0;
      end else if (tick_r) begin
         now_ms_r <= now_ms_r + 32'h1;
         win_r <= (win_r == WIN_LAST) ? 10'h0 : win_r + 10'h1;
         ref_r <= (ref_r == REF_LAST) ? 10'h0 : ref_r + 10'h1;
      end
   end

   // bus slave: one wait state, then data and waitrequest low together
   logic wait_r;
   logic [31:0] rdata_r;
   wire wr_go = avs_write && !wait_r;
   wire per_acc = avs_address[dic_pkg::PER_SEL_BIT];
   wire [4:0] idx = avs_address[dic_pkg::IDX_MSB:dic_pkg::IDX_LSB];
   wire [2:0] off = avs_address[dic_pkg::OFF_MSB:dic_pkg::OFF_LSB];
   wire idx_ok = (32'(idx) < N_IN);
   wire glob_wr = wr_go && !per_acc;
   wire trig_wr = glob_wr && (avs_address == dic_pkg::REG_TRIGGER);
   wire [1:0] trig_val = avs_writedata[1:0];
   wire trig_ok = trig_wr && (avs_writedata[31:2] == 30'h0);
   wire do_clear = trig_ok && (trig_val == dic_pkg::TRIG_CLEAR);
   wire do_upd = trig_ok && (trig_val == dic_pkg::TRIG_UPDATED);
   wire do_all = trig_ok && (trig_val == dic_pkg::TRIG_ALL);

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         wait_r <= 1'b1;
      end else begin
         wait_r <= !((avs_read || avs_write) && wait_r);
      end
   end

   // global configuration and chatter events
   logic [7:0] osc_level_r;
   logic [7:0] osc_hyst_r;
   logic [N_IN-1:0] evt_r;
   logic [N_IN-1:0] evt_set;
   wire evt_wr = glob_wr && (avs_address == dic_pkg::REG_EVENT);
   wire [N_IN-1:0] evt_clr = evt_wr ? avs_writedata[N_IN-1:0] : '0;
   // a new event beats a clear in the same cycle
   wire [N_IN-1:0] evt_nxt = (evt_r & ~evt_clr) | evt_set;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         osc_level_r <= dic_pkg::OSC_LEVEL_DEF;
         osc_hyst_r <= dic_pkg::OSC_HYST_DEF;
         evt_r <= '0;
      end else begin
         if (glob_wr && (avs_address == dic_pkg::REG_OSC_LEVEL))
            osc_level_r <= avs_writedata[7:0];
         if (glob_wr && (avs_address == dic_pkg::REG_OSC_HYST))
            osc_hyst_r <= avs_writedata[7:0];
         evt_r <= evt_nxt;
      end
   end

   // per-input state
   logic [15:0] filt_r [N_IN];
   logic inv_r [N_IN];
   logic [1:0] mode_r [N_IN];
   logic lvl_r [N_IN];
   logic pend_r [N_IN];
   logic [15:0] fcnt_r [N_IN];
   logic [31:0] start_r [N_IN];
   logic stat_r [N_IN];
   logic [31:0] stamp_r [N_IN];
   logic blk_r [N_IN];
   logic [9:0] chg_r [N_IN];
   logic [30:0] tally_r [N_IN];
   logic [30:0] shown_r [N_IN];
   logic [30:0] preset_r [N_IN];
   logic dirty_r [N_IN];
   logic pulse_r [N_IN];
   logic [N_IN-1:0] live;
   logic [31:0] per_word [N_IN][8];

   genvar gi;
   generate
      for (gi = 0; gi < N_IN; gi++) begin : g_in
         wire pwr = wr_go && per_acc && (32'(idx) == gi);
         wire differs = (field_in[gi] != lvl_r[gi]);
         wire [16:0] fnext = {1'b0, fcnt_r[gi]} + 17'h1;
         // filter expiry on a tick, counted from when the change began
         wire accept = pend_r[gi] && differs && tick_r && (fnext >= {1'b0, filt_r[gi]});
         wire rise = accept && (field_in[gi] ^ inv_r[gi]);
         wire [10:0] chg_tot = {1'b0, chg_r[gi]} + {10'h0, accept};
         wire over = (chg_tot > {3'h0, osc_level_r});
         // margin added on the left so a bad margin cannot wrap around
         wire under = ((chg_tot + {3'h0, osc_hyst_r}) < {3'h0, osc_level_r});
         wire go_blk = win_end && !blk_r[gi] && over;
         wire go_free = win_end && blk_r[gi] && under;
         wire can_cnt = CNT_MASK[gi];
         wire [1:0] mode_w = avs_writedata[dic_pkg::CFG_MODE_MSB:dic_pkg::CFG_MODE_LSB];
         wire mode_ok = (mode_w == dic_pkg::MODE_INPUT) ||
                        ((mode_w == dic_pkg::MODE_COUNT) && can_cnt);
         wire load = do_all || (do_upd && dirty_r[gi]);

         assign evt_set[gi] = go_blk || go_free;
         assign live[gi] = stat_r[gi];
         assign din_status[gi] = stat_r[gi];
         assign line_invalid_flag[gi] = blk_r[gi];
         assign osc_event[gi] = pulse_r[gi];
         assign per_word[gi][dic_pkg::OFF_FILTER] = {16'h0, filt_r[gi]};
         assign per_word[gi][dic_pkg::OFF_CFG] = {29'h0, mode_r[gi], inv_r[gi]};
         assign per_word[gi][dic_pkg::OFF_STATUS] = {30'h0, blk_r[gi], stat_r[gi]};
         assign per_word[gi][dic_pkg::OFF_STAMP] = stamp_r[gi];
         assign per_word[gi][dic_pkg::OFF_PRESET] = {1'b0, preset_r[gi]};
         assign per_word[gi][dic_pkg::OFF_COUNT] = {1'b0, shown_r[gi]};
         assign per_word[gi][6] = 32'h0;
         assign per_word[gi][7] = 32'h0;

         always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
               filt_r[gi] <= dic_pkg::FILT_DEF_MS;
               inv_r[gi] <= 1'b0;
               mode_r[gi] <= dic_pkg::MODE_INPUT;
               preset_r[gi] <= '0;
               dirty_r[gi] <= 1'b0;
            end else begin
               if (pwr && (off == dic_pkg::OFF_FILTER))
                  filt_r[gi] <= avs_writedata[15:0];
               if (pwr && (off == dic_pkg::OFF_CFG)) begin
                  inv_r[gi] <= avs_writedata[dic_pkg::CFG_INV_BIT];
                  if (mode_ok)
                     mode_r[gi] <= mode_w;
               end
               if (pwr && (off == dic_pkg::OFF_PRESET)) begin
                  preset_r[gi] <= avs_writedata[30:0];
                  dirty_r[gi] <= 1'b1;
               end else if (load) begin
                  dirty_r[gi] <= 1'b0;
               end
            end
         end

         always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
               lvl_r[gi] <= 1'b0;
               pend_r[gi] <= 1'b0;
               fcnt_r[gi] <= '0;
               start_r[gi] <= '0;
            end else if (!differs) begin
               pend_r[gi] <= 1'b0;
               fcnt_r[gi] <= '0;
            end else if (!pend_r[gi]) begin
               pend_r[gi] <= 1'b1;
               start_r[gi] <= now_ms_r;
               fcnt_r[gi] <= '0;
            end else if (accept) begin
               lvl_r[gi] <= field_in[gi];
               pend_r[gi] <= 1'b0;
            end else if (tick_r) begin
               fcnt_r[gi] <= fnext[15:0];
            end
         end

         always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
               stat_r[gi] <= 1'b0;
               stamp_r[gi] <= '0;
               blk_r[gi] <= 1'b0;
               chg_r[gi] <= '0;
               pulse_r[gi] <= 1'b0;
            end else begin
               if (!blk_r[gi])
                  stat_r[gi] <= lvl_r[gi] ^ inv_r[gi];
               if (accept && !blk_r[gi])
                  stamp_r[gi] <= start_r[gi];
               if (win_end)
                  chg_r[gi] <= '0;
               else if (accept && (chg_r[gi] != dic_pkg::CHG_MAX))
                  chg_r[gi] <= chg_tot[9:0];
               if (go_blk)
                  blk_r[gi] <= 1'b1;
               else if (go_free)
                  blk_r[gi] <= 1'b0;
               pulse_r[gi] <= go_blk || go_free;
            end
         end

         always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
               tally_r[gi] <= '0;
               shown_r[gi] <= '0;
            end else begin
               if (do_clear)
                  tally_r[gi] <= '0;
               else if (load)
                  tally_r[gi] <= preset_r[gi];
               else if ((mode_r[gi] == dic_pkg::MODE_COUNT) && rise &&
                        (tally_r[gi] != dic_pkg::TALLY_MAX))
                  tally_r[gi] <= tally_r[gi] + 31'h1;
               if (ref_end)
                  shown_r[gi] <= tally_r[gi];
            end
         end
      end
   endgenerate

   // read decode
   // index cut to the array's own width; idx_ok turns out-of-range picks into zero
   localparam int IDXW = (N_IN > 1) ? $clog2(N_IN) : 1;
   wire [31:0] per_rd = idx_ok ? per_word[idx[IDXW-1:0]][off] : 32'h0;
   wire [31:0] glob_rd =
      (avs_address == dic_pkg::REG_OSC_LEVEL) ? {24'h0, osc_level_r} :
      (avs_address == dic_pkg::REG_OSC_HYST) ? {24'h0, osc_hyst_r} :
      (avs_address == dic_pkg::REG_TIME) ? now_ms_r :
      (avs_address == dic_pkg::REG_EVENT) ? 32'(evt_r) :
      (avs_address == dic_pkg::REG_LIVE) ? 32'(live) : 32'h0;
   wire [31:0] rd_mux = per_acc ? per_rd : glob_rd;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn)
         rdata_r <= '0;
      else if (avs_read && wait_r)
         rdata_r <= rd_mux;
   end

   assign avs_readdata = rdata_r;
   assign avs_waitrequest = wait_r;
endmodule

// >>> include/dic_pkg.sv
// How it works
// - a level change is taken only after it persists for the filter time
// - every input has its own filter time in ms, 5 ms after reset
// - the time stamp is the moment the new level first appeared
// - reported status is control voltage xor the invert bit, invert resets to 0
// - mode code 1 is plain input, code 2 is pulse counter, default 1
// - in plain input mode the tally does not count, but clear and load still act on it
// - counter mode adds one per filtered rising edge, 0 to 2147483647
// - the software-visible tally is refreshed every 500 ms
// - counting keeps up with pulses from 0 to 100 Hz
// - each counter has a start value, default 0, moved only on load
// - trigger 1 loads only start values rewritten since the last load
// - trigger 2 loads every start value
// - trigger 0 clears every tally at once
// - more changes per second than the level blocks the input, with an event
// - a blocked input keeps the state it had before blocking
// - fewer changes than level minus margin releases it, with an event
// - time stamps are accurate to within one millisecond
// - the invalid flag reads 1 while blocked, 0 while operative
package dic_pkg;
   localparam int CLK_HZ = 40_000_000;
   localparam int TICK_MS = 1;
   localparam int MS_CYCLES = CLK_HZ / 1000 * TICK_MS;
   localparam int WIN_MS = 1000;
   localparam int REFRESH_MS = 500;
   localparam logic [15:0] FILT_DEF_MS = 16'h0005;
   localparam logic [7:0] OSC_LEVEL_DEF = 8'h32;
   localparam logic [7:0] OSC_HYST_DEF = 8'h0A;
   localparam logic [30:0] TALLY_MAX = 31'h7FFFFFFF;
   localparam logic [9:0] CHG_MAX = 10'h3FF;
   localparam logic [1:0] MODE_INPUT = 2'h1;
   localparam logic [1:0] MODE_COUNT = 2'h2;
   localparam logic [1:0] TRIG_CLEAR = 2'h0;
   localparam logic [1:0] TRIG_UPDATED = 2'h1;
   localparam logic [1:0] TRIG_ALL = 2'h2;
   // global registers, byte addresses
   localparam logic [11:0] REG_TRIGGER = 12'h000;
   localparam logic [11:0] REG_OSC_LEVEL = 12'h004;
   localparam logic [11:0] REG_OSC_HYST = 12'h008;
   localparam logic [11:0] REG_TIME = 12'h00C;
   localparam logic [11:0] REG_EVENT = 12'h010;
   localparam logic [11:0] REG_LIVE = 12'h014;
   // per-input block: address bit 10 set, index in bits 9..5, word in 4..2
   localparam int PER_SEL_BIT = 10;
   localparam int IDX_MSB = 9;
   localparam int IDX_LSB = 5;
   localparam int OFF_MSB = 4;
   localparam int OFF_LSB = 2;
   localparam logic [2:0] OFF_FILTER = 3'h0;
   localparam logic [2:0] OFF_CFG = 3'h1;
   localparam logic [2:0] OFF_STATUS = 3'h2;
   localparam logic [2:0] OFF_STAMP = 3'h3;
   localparam logic [2:0] OFF_PRESET = 3'h4;
   localparam logic [2:0] OFF_COUNT = 3'h5;
   localparam int CFG_INV_BIT = 0;
   localparam int CFG_MODE_LSB = 1;
   localparam int CFG_MODE_MSB = 2;
endpackage

// >>> tb/dic_field.sv
module dic_field #(parameter int BOUNCE = 3) (
   input wire logic clk_sys,
   input wire logic [1:0] level,
   output logic [1:0] field_in
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [1:0] last_r = 2'h0;
   logic [1:0] flip_r = 2'h0;
   int cnt_r = 0;
   // contacts bounce a few cycles on each change, well inside one ms
   always @(posedge clk_sys) begin
      if (level != last_r) begin
         cnt_r <= BOUNCE;
         flip_r <= level ^ last_r;
      end else if (cnt_r != 0) begin
         cnt_r <= cnt_r - 1;
      end
      last_r <= level;
   end
   assign field_in = level ^ (cnt_r[0] ? flip_r : 2'h0);
endmodule

// >>> tb/dic_top_sva.sv
module dic_top_sva #(
   parameter int N_IN = 8,
   parameter int MS_CYCLES = 40000
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic [N_IN-1:0] field_in,
   input wire logic [11:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic [N_IN-1:0] din_status,
   input wire logic [N_IN-1:0] line_invalid_flag,
   input wire logic [N_IN-1:0] osc_event
);
   timeunit 1ns;
   timeprecision 100ps;
   int stab_r;
   int gap_r;
   logic seen_r;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   // stab_r: cycles input 0 held still; gap_r: cycles since the flag last moved
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         stab_r <= 0;
         gap_r <= 0;
         seen_r <= 1'b0;
      end else begin
         stab_r <= $changed(field_in[0]) ? 0 : stab_r + 1;
         gap_r <= $changed(line_invalid_flag[0]) ? 1 : gap_r + 1;
         seen_r <= seen_r | $changed(line_invalid_flag[0]);
      end
   end
   chk_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("waitrequest not low one cycle after request");
   chk_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low longer than one cycle");
   chk_trig_reads0: assert property (avs_read && !avs_waitrequest
      && avs_address == dic_pkg::REG_TRIGGER |-> avs_readdata == 32'h0)
      else $error("trigger register read not zero");
   chk_filter_hold: assert property ($changed(din_status[0]) |-> stab_r >= 3 * MS_CYCLES)
      else $error("status moved before input settled");
   chk_window_edge: assert property ($changed(line_invalid_flag[0]) && seen_r
      |-> gap_r % (1000 * MS_CYCLES) == 0)
      else $error("invalid flag moved off a window end");
   chk_event_follow: assert property ($changed(line_invalid_flag[0]) |-> ##[0:1] osc_event[0])
      else $error("no event on block or release");
   chk_event_pulse: assert property (osc_event[0] |=> !osc_event[0])
      else $error("event longer than one cycle");
   chk_frozen_state: assert property (line_invalid_flag[0] && $past(line_invalid_flag[0])
      |-> $stable(din_status[0]))
      else $error("blocked status changed");
endmodule
bind dic_top dic_top_sva #(.N_IN(N_IN), .MS_CYCLES(MS_CYCLES)) u_sva (.clk_sys(clk_sys),
   .rstn(rstn), .field_in(field_in), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .din_status(din_status), .line_invalid_flag(line_invalid_flag), .osc_event(osc_event));

// >>> tb/dic_top_tb_top.sv
module dic_top_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int MS = 8;
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   logic [1:0] lv = 2'h0;
   logic [1:0] field_in, din_status, line_invalid_flag, osc_event;
   logic [11:0] avs_address = 12'h000;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata, q, t0;
   logic avs_waitrequest, s;
   int num_errors = 0;
   int n_tests = 0;
   dic_top #(.N_IN(2), .CNT_MASK(32'h00000003), .MS_CYCLES(MS)) DUT (.clk_sys(clk_sys),
      .rstn(rstn), .field_in(field_in), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .din_status(din_status),
      .line_invalid_flag(line_invalid_flag), .osc_event(osc_event));
   dic_field u_field (.clk_sys(clk_sys), .level(lv), .field_in(field_in));
   initial begin
      forever #12.5 clk_sys = ~clk_sys;
   end
   task automatic results();
      if (num_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic ms(input int n);
      repeat (n * MS) @(posedge clk_sys);
   endtask
   // waitrequest and readdata are read at the falling edge, once settled;
   // reading them just after the rising edge races with the slave's own update
   task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] d);
      logic w;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(negedge clk_sys);
         w = avs_waitrequest;
         q = avs_readdata;
         @(posedge clk_sys);
      end while (w !== 1'b0);
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      acc(1'b0, a, 32'h0);
      chk(q, exp);
   endtask
   task automatic pulse(input int n);
      repeat (n) begin
         lv <= 2'h3;
         ms(6);
         lv <= 2'h0;
         ms(6);
      end
   endtask
   // tallies only become visible at the next half-second refresh
   task automatic cnts(input logic [31:0] e0, input logic [31:0] e1);
      ms(510);
      rdc(12'h414, e0);
      rdc(12'h434, e1);
   endtask
   initial begin
      repeat (3) @(posedge clk_sys);
      rstn <= 1'b1;
      @(posedge clk_sys);
      rdc(12'h400, 32'h5);
      rdc(12'h404, 32'h2);
      rdc(12'h430, 32'h0);
      rdc(12'h004, 32'h32);
      rdc(12'h008, 32'hA);
      rdc(12'h100, 32'h0);
      rdc(12'h000, 32'h0);
      // mode code 3 is refused while the invert bit still lands
      acc(1'b1, 12'h404, 32'h6);
      rdc(12'h404, 32'h2);
      lv <= 2'h1;
      ms(2);
      lv <= 2'h0;
      ms(6);
      rdc(12'h408, 32'h0);
      acc(1'b0, 12'h00C, 32'h0);
      t0 = q;
      lv <= 2'h1;
      ms(6);
      chk({31'h0, din_status[0]}, 32'h1);
      acc(1'b0, 12'h40C, 32'h0);
      chk({31'h0, (q - t0) <= 32'h1}, 32'h1);
      acc(1'b1, 12'h420, 32'h2);
      lv <= 2'h3;
      ms(3);
      chk({31'h0, din_status[1]}, 32'h1);
      acc(1'b1, 12'h424, 32'h3);
      rdc(12'h428, 32'h0);
      lv <= 2'h1;
      ms(4);
      acc(1'b1, 12'h424, 32'h4);
      pulse(3);
      cnts(32'h0, 32'h3);
      acc(1'b1, 12'h430, 32'h64);
      pulse(1);
      cnts(32'h0, 32'h4);
      acc(1'b1, 12'h000, 32'h1);
      cnts(32'h0, 32'h64);
      acc(1'b1, 12'h410, 32'h7);
      pulse(1);
      acc(1'b1, 12'h000, 32'h1);
      cnts(32'h7, 32'h65);
      pulse(1);
      acc(1'b1, 12'h000, 32'h2);
      cnts(32'h7, 32'h64);
      // upper trigger bits set: ignored, must not act as a clear
      acc(1'b1, 12'h000, 32'h4);
      cnts(32'h7, 32'h64);
      acc(1'b1, 12'h000, 32'h0);
      cnts(32'h0, 32'h0);
      acc(1'b1, 12'h004, 32'h4);
      acc(1'b1, 12'h008, 32'h2);
      for (int k = 0; k < 400 && line_invalid_flag[0] !== 1'b1; k++) begin
         lv[0] <= ~lv[0];
         ms(6);
      end
      acc(1'b0, 12'h408, 32'h0);
      chk(q & 32'h2, 32'h2);
      rdc(12'h010, 32'h1);
      acc(1'b1, 12'h010, 32'h1);
      rdc(12'h010, 32'h0);
      s = din_status[0];
      repeat (3) begin
         lv[0] <= ~lv[0];
         ms(6);
      end
      chk({31'h0, din_status[0]}, {31'h0, s});
      for (int k = 0; k < 3000 && line_invalid_flag[0] !== 1'b0; k++) ms(1);
      chk({31'h0, line_invalid_flag[0]}, 32'h0);
      rdc(12'h010, 32'h1);
      results();
   end
   // about 48k cycles at most expected, so this only trips on a hang
   initial begin
      repeat (90000) @(posedge clk_sys);
      num_errors++;
      results();
   end
endmodule
